// ===== fec_cap_calc.sv
// Grant capacity in bytes: slots times symbols, less guard, times bits per symbol
`timescale 1ns/100ps
`default_nettype none
module fec_cap_calc (
  input wire logic clk,
  input wire logic nrst,
  fec_cap_if.calc cap
);
  logic [fec_fill_pkg::CAP_W-1:0] syms;
  logic [fec_fill_pkg::CAP_W-1:0] bits;
  logic [fec_fill_pkg::CAP_W-1:0] cap_d;
  logic [fec_fill_pkg::CAP_W-1:0] cap_q;
  logic done_d;
  logic done_q;

  always_comb begin
    syms = fec_fill_pkg::CAP_W'(cap.slots) * fec_fill_pkg::CAP_W'(cap.syms_per_slot);
    if (syms > fec_fill_pkg::CAP_W'(cap.guard_syms)) begin
      syms = syms - fec_fill_pkg::CAP_W'(cap.guard_syms);
    end else begin
      syms = '0;
    end
    // QPSK two bits per symbol, 16QAM four
    if (cap.modulation == fec_fill_pkg::MOD_16QAM) begin
      bits = syms * fec_fill_pkg::CAP_W'(fec_fill_pkg::BITS_16QAM);
    end else begin
      bits = syms * fec_fill_pkg::CAP_W'(fec_fill_pkg::BITS_QPSK);
    end
    cap_d = cap.start ? (bits >> 3) : cap_q;
    done_d = cap.start;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cap_q <= '0;
      done_q <= 1'b0;
    end else begin
      cap_q <= cap_d;
      done_q <= done_d;
    end
  end

  assign cap.cap_bytes = cap_q;
  assign cap.done = done_q;
endmodule : fec_cap_calc
`default_nettype wire

// ===== fec_cap_if.sv
// Interface carrying the grant capacity request and answer
`timescale 1ns/100ps
`default_nettype none
interface fec_cap_if;
  logic start;
  logic [fec_fill_pkg::SLOTS_W-1:0] slots;
  logic [fec_fill_pkg::SYMS_W-1:0] syms_per_slot;
  logic [fec_fill_pkg::GUARD_W-1:0] guard_syms;
  fec_fill_pkg::mod_type modulation;
  logic done;
  logic [fec_fill_pkg::CAP_W-1:0] cap_bytes;
  modport calc (input start, slots, syms_per_slot, guard_syms, modulation, output done, cap_bytes);
  modport user (output start, slots, syms_per_slot, guard_syms, modulation, input done, cap_bytes);
endinterface : fec_cap_if
`default_nettype wire

// ===== fec_fill_framer.sv
// Upstream burst framer: splits data into codewords and zero-fills the grant while a codeword still fits
`timescale 1ns/100ps
`default_nettype none
module fec_fill_framer #(
  parameter int unsigned MAX_K = 255
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  // Burst setup, sampled on I_START; I_16QAM and the grant size inputs in the cycle after
  input wire logic I_START,
  input wire logic I_FEC_EN,
  input wire logic I_SHORTENED,
  input wire logic I_16QAM,
  input wire logic [2:0] I_RATE,
  input wire logic I_CONTENTION,
  input wire logic [7:0] I_K,
  input wire logic [4:0] I_PARITY,
  input wire logic [9:0] I_SLOTS,
  input wire logic [7:0] I_SYMS_PER_SLOT,
  input wire logic [7:0] I_GUARD_SYMS,
  input wire logic [15:0] I_LEN,
  // Request sizing
  input wire logic [15:0] I_REQ_LEN,
  output logic [23:0] O_REQ_BYTES,
  // MAC data in
  input wire logic I_DATA_VALID,
  input wire logic [7:0] I_DATA,
  output logic O_DATA_READY,
  // Coded byte stream out
  output logic O_VALID,
  output logic [7:0] O_BYTE,
  output logic O_FILL,
  output logic O_CW_START,
  output logic O_CW_END,
  output logic [7:0] O_CW_LEN,
  // Status
  output logic O_BUSY,
  output logic O_DONE,
  output logic O_ERR
);
  // Codeword length counters are eight bits wide
  if (MAX_K > 255 || MAX_K < fec_fill_pkg::MIN_INFO_BYTES) begin : g_bad_max_k
    $error("MAX_K out of range");
  end

  typedef enum logic [2:0] {IDLE, CALC, PLAN, EMIT, FINISH} state_type;

  fec_cap_if cap_bus ();
  fec_cap_calc u_cap (
    .clk(I_CLK),
    .nrst(I_NRST),
    .cap(cap_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  state_type state_q, state_d;
  fec_fill_pkg::cw_mode_type mode_q, mode_d;
  logic fec_q, fec_d;
  logic [7:0] k_q, k_d;
  logic [4:0] par_q, par_d;
  logic [15:0] left_q, left_d;
  logic [23:0] room_q, room_d;
  logic [7:0] cw_len_q, cw_len_d;
  logic [7:0] pos_q, pos_d;
  logic valid_q, valid_d;
  logic [7:0] byte_q, byte_d;
  logic fill_q, fill_d;
  logic cws_q, cws_d;
  logic cwe_q, cwe_d;
  logic [7:0] olen_q, olen_d;
  logic done_q, done_d;
  logic err_q, err_d;
  logic [23:0] req_q, req_d;
  logic rdy_q, rdy_d;
  logic pad_q, pad_d;
  logic busy_q, busy_d;
  logic [23:0] full_cw;
  logic [23:0] req_cw;
  logic [23:0] req_tail;
  logic take;
  logic k_bad;

  assign cap_bus.start = (state_q == CALC);
  assign cap_bus.slots = I_SLOTS;
  assign cap_bus.syms_per_slot = I_SYMS_PER_SLOT;
  assign cap_bus.guard_syms = I_GUARD_SYMS;
  assign cap_bus.modulation = I_16QAM ? fec_fill_pkg::MOD_16QAM : fec_fill_pkg::MOD_QPSK;

  // Codeword cost on the wire: info plus two parity bytes per corrected error
  assign full_cw = 24'(k_q) + 24'({par_q, 1'b0});
  assign take = (state_q == EMIT) && !fill_q && I_DATA_VALID && rdy_q;
  assign k_bad = (I_K < fec_fill_pkg::K_MIN) || (32'(I_K) > MAX_K);

  // Request sizing: whole codewords plus a tail of at least sixteen bytes
  always_comb begin
    req_cw = 24'(I_REQ_LEN / 16'(I_K == 8'h00 ? 8'h01 : I_K));
    req_tail = 24'(I_REQ_LEN) - req_cw * 24'(I_K);
    if (req_tail != 24'h000000 && req_tail < 24'(fec_fill_pkg::K_MIN)) begin
      req_tail = 24'(fec_fill_pkg::K_MIN);
    end
    if (req_tail != 24'h000000) begin
      req_tail = req_tail + 24'({I_PARITY, 1'b0});
    end
    req_d = req_cw * (24'(I_K) + 24'({I_PARITY, 1'b0})) + req_tail;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    fec_d = fec_q;
    k_d = k_q;
    par_d = par_q;
    left_d = left_q;
    room_d = room_q;
    cw_len_d = cw_len_q;
    pos_d = pos_q;
    valid_d = 1'b0;
    byte_d = byte_q;
    fill_d = fill_q;
    cws_d = 1'b0;
    cwe_d = 1'b0;
    olen_d = olen_q;
    done_d = 1'b0;
    err_d = err_q;
    rdy_d = 1'b0;
    pad_d = 1'b0;
    unique case (state_q)
      IDLE: begin
        if (I_START) begin
          // Contention flag does not change framing
          mode_d = I_SHORTENED ? fec_fill_pkg::MODE_SHORTENED : fec_fill_pkg::MODE_FIXED;
          fec_d = I_FEC_EN;
          k_d = I_K;
          par_d = I_FEC_EN ? I_PARITY : 5'h00;
          left_d = I_LEN;
          err_d = I_FEC_EN && k_bad;
          fill_d = 1'b0;
          pos_d = 8'h00;
          state_d = (I_FEC_EN && k_bad) ? FINISH : CALC;
        end
      end
      CALC: begin
        if (cap_bus.done) begin
          room_d = cap_bus.cap_bytes;
          state_d = PLAN;
        end
      end
      PLAN: begin
        // Decide the next codeword against what is left of the grant
        if (!fec_q) begin
          cw_len_d = (room_q >= 24'h0000FF) ? 8'hFF : room_q[7:0];
          fill_d = (left_q == 16'h0000);
          state_d = (room_q == 24'h000000) ? FINISH : EMIT;
          err_d = err_q || (room_q == 24'h000000 && left_q != 16'h0000);
        end else if (room_q >= full_cw) begin
          cw_len_d = k_q;
          fill_d = (left_q == 16'h0000);
          room_d = room_q - 24'({par_q, 1'b0});
          state_d = EMIT;
        end else if (mode_q == fec_fill_pkg::MODE_SHORTENED &&
                     room_q >= 24'(fec_fill_pkg::K_MIN) + 24'({par_q, 1'b0})) begin
          cw_len_d = 8'(room_q - 24'({par_q, 1'b0}));
          fill_d = (left_q == 16'h0000);
          room_d = room_q - 24'({par_q, 1'b0});
          state_d = EMIT;
        end else begin
          // Under sixteen bytes plus parity left, or fixed mode with no full codeword room
          err_d = err_q || (left_q != 16'h0000);
          state_d = FINISH;
        end
        pos_d = 8'h00;
        rdy_d = (state_d == EMIT) && (left_q != 16'h0000);
      end
      EMIT: begin
        if (fill_q || take) begin
          valid_d = 1'b1;
          byte_d = take ? I_DATA : fec_fill_pkg::ZERO_BYTE;
          cws_d = (pos_q == 8'h00);
          cwe_d = (pos_q == cw_len_q - 8'h01);
          olen_d = cw_len_q;
          // Marked per byte, so a data byte of zero is never taken for fill
          pad_d = !take;
          pos_d = pos_q + 8'h01;
          room_d = room_q - 24'h000001;
          if (take) begin
            left_d = left_q - 16'h0001;
            fill_d = (left_q == 16'h0001);
          end
          if (pos_q == cw_len_q - 8'h01) begin
            state_d = PLAN;
          end
        end
        rdy_d = (state_d == EMIT) && !fill_d;
      end
      FINISH: begin
        done_d = 1'b1;
        state_d = IDLE;
      end
      default: state_d = IDLE;
    endcase
    busy_d = (state_d != IDLE);
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      state_q <= IDLE;
      mode_q <= fec_fill_pkg::MODE_FIXED;
      fec_q <= 1'b0;
      k_q <= 8'h00;
      par_q <= 5'h00;
      left_q <= 16'h0000;
      room_q <= 24'h000000;
      cw_len_q <= 8'h00;
      pos_q <= 8'h00;
      valid_q <= 1'b0;
      byte_q <= 8'h00;
      fill_q <= 1'b0;
      cws_q <= 1'b0;
      cwe_q <= 1'b0;
      olen_q <= 8'h00;
      done_q <= 1'b0;
      err_q <= 1'b0;
      req_q <= 24'h000000;
      rdy_q <= 1'b0;
      pad_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      fec_q <= fec_d;
      k_q <= k_d;
      par_q <= par_d;
      left_q <= left_d;
      room_q <= room_d;
      cw_len_q <= cw_len_d;
      pos_q <= pos_d;
      valid_q <= valid_d;
      byte_q <= byte_d;
      fill_q <= fill_d;
      cws_q <= cws_d;
      cwe_q <= cwe_d;
      olen_q <= olen_d;
      done_q <= done_d;
      err_q <= err_d;
      req_q <= req_d;
      rdy_q <= rdy_d;
      pad_q <= pad_d;
      busy_q <= busy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign O_REQ_BYTES = req_q;
  assign O_DATA_READY = rdy_q;
  assign O_VALID = valid_q;
  assign O_BYTE = byte_q;
  assign O_FILL = pad_q;
  assign O_CW_START = cws_q;
  assign O_CW_END = cwe_q;
  assign O_CW_LEN = olen_q;
  assign O_BUSY = busy_q;
  assign O_DONE = done_q;
  assign O_ERR = err_q;
endmodule : fec_fill_framer
`default_nettype wire

// ===== fec_fill_framer_sva.sv
// Port-level property checker for the upstream codeword framer
`timescale 1ns/100ps
`default_nettype none
module fec_fill_framer_sva (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  // Watched inputs
  input wire logic I_START,
  input wire logic I_FEC_EN,
  input wire logic I_SHORTENED,
  input wire logic [7:0] I_K,
  input wire logic [4:0] I_PARITY,
  input wire logic [15:0] I_REQ_LEN,
  input wire logic I_DATA_VALID,
  input wire logic [7:0] I_DATA,
  // Watched outputs
  input wire logic O_DATA_READY,
  input wire logic O_VALID,
  input wire logic [7:0] O_BYTE,
  input wire logic O_FILL,
  input wire logic O_CW_START,
  input wire logic O_CW_END,
  input wire logic [7:0] O_CW_LEN,
  input wire logic [23:0] O_REQ_BYTES,
  input wire logic O_BUSY,
  input wire logic O_DONE
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  ////////////////////////////////////////////////////////////////////////////////
  chk_min_len: assert property (I_FEC_EN && O_CW_START |-> O_CW_LEN >= fec_fill_pkg::K_MIN)
    else $error("codeword below minimum");
  chk_short_max: assert property (I_FEC_EN && O_CW_START |-> O_CW_LEN <= I_K)
    else $error("codeword above k");
  chk_fixed_len: assert property (I_FEC_EN && !I_SHORTENED && O_CW_START |-> O_CW_LEN == I_K)
    else $error("fixed codeword not k long");
  chk_fill_zero: assert property (O_VALID && O_FILL |-> O_BYTE == fec_fill_pkg::ZERO_BYTE)
    else $error("fill byte not zero");
  chk_take_echo: assert property (I_DATA_VALID && O_DATA_READY |=> O_VALID && !O_FILL && O_BYTE == $past(I_DATA))
    else $error("taken byte not passed on");
  chk_busy_start: assert property (I_START && !O_BUSY && I_K >= 8'h10 |=> O_BUSY)
    else $error("start did not raise busy");
  chk_done_once: assert property (O_DONE |=> !O_DONE)
    else $error("done longer than one cycle");
  chk_strobe_in_byte: assert property (O_CW_START || O_CW_END |-> O_VALID)
    else $error("codeword mark without byte");
  chk_cw_gap: assert property (O_CW_END |=> !O_VALID)
    else $error("no planning cycle after codeword");
  chk_req_tail: assert property (I_REQ_LEN != 16'h0000 && I_REQ_LEN <= 16'(I_K) && I_K >= 8'h10 |=>
    O_REQ_BYTES == 24'($past(I_REQ_LEN) < 16'h0010 ? 16'h0010 : $past(I_REQ_LEN)) + 24'({$past(I_PARITY), 1'b0}))
    else $error("request size wrong");
endmodule : fec_fill_framer_sva
bind fec_fill_framer fec_fill_framer_sva u_sva (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_START(I_START),
  .I_FEC_EN(I_FEC_EN), .I_SHORTENED(I_SHORTENED), .I_K(I_K), .I_PARITY(I_PARITY), .I_REQ_LEN(I_REQ_LEN),
  .I_DATA_VALID(I_DATA_VALID), .I_DATA(I_DATA), .O_DATA_READY(O_DATA_READY), .O_VALID(O_VALID),
  .O_BYTE(O_BYTE), .O_FILL(O_FILL), .O_CW_START(O_CW_START), .O_CW_END(O_CW_END), .O_CW_LEN(O_CW_LEN),
  .O_REQ_BYTES(O_REQ_BYTES), .O_BUSY(O_BUSY), .O_DONE(O_DONE));
`default_nettype wire

// ===== fec_fill_pkg.sv
// Shared constants and types for the upstream codeword framer
package fec_fill_pkg;
  localparam int unsigned MIN_INFO_BYTES = 16;
  localparam int unsigned KBYTES_W = 8;
  localparam int unsigned PARITY_W = 5;
  localparam int unsigned SLOTS_W = 10;
  localparam int unsigned SYMS_W = 8;
  localparam int unsigned GUARD_W = 8;
  localparam int unsigned CAP_W = 24;
  localparam logic [KBYTES_W-1:0] K_MIN = 8'h10;
  localparam logic [1:0] BITS_QPSK = 2'h2;
  localparam logic [2:0] BITS_16QAM = 3'h4;
  localparam logic [2:0] RATE_160K = 3'h0;
  localparam logic [2:0] RATE_2560K = 3'h4;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  typedef enum logic {MODE_FIXED, MODE_SHORTENED} cw_mode_type;
  typedef enum logic {MOD_QPSK, MOD_16QAM} mod_type;
endpackage : fec_fill_pkg

// ===== fec_rx_model.sv
// Headend receiver model: splits the coded stream back into codewords
`timescale 1ns/100ps
`default_nettype none
module fec_rx_model (
  // Clock and burst start
  input wire logic i_clk,
  input wire logic i_clear,
  // Framer output stream
  input wire logic i_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_fill,
  input wire logic i_cw_start,
  input wire logic i_cw_end,
  input wire logic [7:0] i_cw_len
);
  int unsigned cw_count = 0;
  int unsigned bad_count = 0;
  int unsigned in_cw = 0;
  logic [7:0] lens [0:15];
  logic [7:0] data_q [$];
  always @(posedge i_clk) begin
    if (i_clear) begin
      cw_count = 0;
      bad_count = 0;
      data_q.delete();
    end else if (i_valid) begin
      if (i_cw_start) in_cw = 0;
      in_cw++;
      if (i_fill && i_byte !== 8'h00) bad_count++;
      if (!i_fill) data_q.push_back(i_byte);
      if (i_cw_end) begin
        // Byte count must match the announced length
        if (in_cw != i_cw_len || i_cw_len < 8'h10) bad_count++;
        lens[cw_count[3:0]] = i_cw_len;
        cw_count++;
      end
    end
  end
endmodule : fec_rx_model
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the upstream codeword framer
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic I_CLK = 1'b0, I_NRST = 1'b0, I_START = 1'b0, I_FEC_EN = 1'b1, I_SHORTENED = 1'b0, I_16QAM = 1'b0;
  logic I_CONTENTION = 1'b0, I_DATA_VALID = 1'b0;
  logic [2:0] I_RATE = 3'h0;
  logic [4:0] I_PARITY = 5'h00;
  logic [7:0] I_K = 8'h10, I_SYMS_PER_SLOT = 8'h00, I_GUARD_SYMS = 8'h00, I_DATA = 8'h00;
  logic [9:0] I_SLOTS = 10'h000;
  logic [15:0] I_LEN = 16'h0000, I_REQ_LEN = 16'h0000;
  logic O_DATA_READY, O_VALID, O_FILL, O_CW_START, O_CW_END, O_BUSY, O_DONE, O_ERR;
  logic [7:0] O_BYTE, O_CW_LEN;
  logic [23:0] O_REQ_BYTES;
  int fail_count = 0, comparisons = 0, cycles = 0;
  fec_fill_framer dut (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_START(I_START), .I_FEC_EN(I_FEC_EN),
    .I_SHORTENED(I_SHORTENED), .I_16QAM(I_16QAM), .I_RATE(I_RATE), .I_CONTENTION(I_CONTENTION), .I_K(I_K),
    .I_PARITY(I_PARITY), .I_SLOTS(I_SLOTS), .I_SYMS_PER_SLOT(I_SYMS_PER_SLOT), .I_GUARD_SYMS(I_GUARD_SYMS),
    .I_LEN(I_LEN), .I_REQ_LEN(I_REQ_LEN), .O_REQ_BYTES(O_REQ_BYTES), .I_DATA_VALID(I_DATA_VALID),
    .I_DATA(I_DATA), .O_DATA_READY(O_DATA_READY), .O_VALID(O_VALID), .O_BYTE(O_BYTE), .O_FILL(O_FILL),
    .O_CW_START(O_CW_START), .O_CW_END(O_CW_END), .O_CW_LEN(O_CW_LEN), .O_BUSY(O_BUSY), .O_DONE(O_DONE),
    .O_ERR(O_ERR));
  fec_rx_model model (.i_clk(I_CLK), .i_clear(I_START), .i_valid(O_VALID), .i_byte(O_BYTE), .i_fill(O_FILL),
    .i_cw_start(O_CW_START), .i_cw_end(O_CW_END), .i_cw_len(O_CW_LEN));
  initial forever #10 I_CLK = ~I_CLK;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // Runs far beyond the few hundred cycles the tests need
  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      final_report();
    end
  end
  task automatic check(input bit ok, input string what);
    comparisons++;
    if (!ok) begin
      fail_count++;
      $display("MISMATCH t=%0t %s", $time, what);
    end
  endtask : check
  task automatic setup(input bit sh, qam, input logic [7:0] k, input logic [4:0] t, input logic [9:0] sl,
                       input logic [7:0] sy, gd);
    @(posedge I_CLK);
    I_SHORTENED <= sh;
    I_16QAM <= qam;
    I_K <= k;
    I_PARITY <= t;
    I_SLOTS <= sl;
    I_SYMS_PER_SLOT <= sy;
    I_GUARD_SYMS <= gd;
  endtask : setup
  task automatic run_burst(input int len, input int ncw);
    bit seen = 1'b0;
    I_LEN <= 16'(len);
    I_START <= 1'b1;
    @(posedge I_CLK);
    I_START <= 1'b0;
    for (int i = 1; i <= len; i++) begin
      I_DATA_VALID <= 1'b1;
      I_DATA <= 8'(i);
      repeat (400) begin
        @(posedge I_CLK);
        if (O_DATA_READY === 1'b1) break;
      end
    end
    I_DATA_VALID <= 1'b0;
    repeat (3000) begin
      @(posedge I_CLK);
      if (O_DONE === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
    @(posedge I_CLK);
    check(seen && O_BUSY === 1'b0, "burst did not finish");
    check(O_ERR === 1'b0, "error flag raised");
    check(model.cw_count == ncw, "codeword count");
    check(model.bad_count == 0, "fill or codeword length");
    check(model.data_q.size() == len, "data byte count");
    for (int i = 0; i < model.data_q.size(); i++) check(model.data_q[i] === 8'(i + 1), "data byte");
  endtask : run_burst
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_bad_k();
    setup(1'b0, 1'b0, 8'h0F, 5'h00, 10'h004, 8'h20, 8'h00);
    I_LEN <= 16'h000A;
    I_START <= 1'b1;
    @(posedge I_CLK);
    I_START <= 1'b0;
    repeat (10) @(posedge I_CLK);
    check(O_ERR === 1'b1, "short k accepted");
    check(O_BUSY === 1'b0, "burst not aborted");
    $display("bad k test done");
  endtask : t_bad_k
  task automatic t_fixed();
    setup(1'b0, 1'b0, 8'h10, 5'h00, 10'h004, 8'h20, 8'h00);
    run_burst(10, 2);
    // Guard and parity leave room for one codeword only
    setup(1'b0, 1'b0, 8'h10, 5'h02, 10'h004, 8'h20, 8'h08);
    run_burst(10, 1);
    $display("fixed test done");
  endtask : t_fixed
  task automatic t_short();
    setup(1'b1, 1'b0, 8'h14, 5'h00, 10'h008, 8'h1D, 8'h00);
    run_burst(20, 3);
    check(model.lens[1] === 8'h14 && model.lens[2] === 8'h12, "zero codeword lengths");
    setup(1'b1, 1'b0, 8'h14, 5'h00, 10'h005, 8'h1C, 8'h00);
    run_burst(20, 1);
    setup(1'b1, 1'b0, 8'h14, 5'h00, 10'h004, 8'h24, 8'h00);
    run_burst(25, 2);
    check(model.lens[0] === 8'h14 && model.lens[1] === 8'h10, "shortened tail length");
    $display("shortened test done");
  endtask : t_short
  task automatic t_rates();
    for (int r = 0; r < 5; r++) begin
      I_RATE <= 3'(r);
      I_CONTENTION <= r[0];
      setup(1'b0, 1'b1, 8'h10, 5'h00, 10'h002, 8'h20, 8'h00);
      run_burst(16, 2);
    end
    $display("rates test done");
  endtask : t_rates
  // Reset in the middle of a burst, then a normal burst must follow
  task automatic t_reset();
    setup(1'b0, 1'b0, 8'h10, 5'h00, 10'h004, 8'h20, 8'h00);
    I_LEN <= 16'h000A;
    I_START <= 1'b1;
    @(posedge I_CLK);
    I_START <= 1'b0;
    repeat (5) @(posedge I_CLK);
    I_NRST <= 1'b0;
    repeat (2) @(posedge I_CLK);
    check(O_BUSY === 1'b0 && O_DATA_READY === 1'b0 && O_VALID === 1'b0 && O_ERR === 1'b0, "reset left state");
    I_NRST <= 1'b1;
    run_burst(10, 2);
    $display("reset test done");
  endtask : t_reset
  // FEC off: no parity, whole grant streamed as one chunk
  task automatic t_raw();
    I_FEC_EN <= 1'b0;
    setup(1'b0, 1'b0, 8'h10, 5'h02, 10'h006, 8'h20, 8'h00);
    run_burst(10, 1);
    check(model.lens[0] === 8'h30, "raw chunk length");
    I_FEC_EN <= 1'b1;
    $display("raw test done");
  endtask : t_raw
  task automatic t_req();
    @(posedge I_CLK);
    I_K <= 8'h14;
    I_PARITY <= 5'h02;
    I_REQ_LEN <= 16'h002D;
    repeat (2) @(posedge I_CLK);
    check(O_REQ_BYTES === 24'h000044, "request size");
    I_REQ_LEN <= 16'h0005;
    repeat (2) @(posedge I_CLK);
    check(O_REQ_BYTES === 24'h000014, "short request size");
    $display("request test done");
  endtask : t_req
  initial begin
    repeat (2) @(posedge I_CLK);
    I_NRST <= 1'b1;
    t_bad_k();
    t_reset();
    t_fixed();
    t_short();
    t_rates();
    t_raw();
    t_req();
    final_report();
  end
endmodule : tb
`default_nettype wire
